// >>> design/region_host_params.svh
// constants for the operand region host controller
`ifndef REGION_HOST_PARAMS_SVH
`define REGION_HOST_PARAMS_SVH

// register byte offsets
`define OFF_CTRL     8'h00
`define OFF_EXEC     8'h04
`define OFF_DST      8'h08
`define OFF_FIRST_SOURCE     8'h0c
`define OFF_SECOND_SOURCE     8'h10
`define OFF_STATUS   8'h14
`define OFF_VIOL     8'h18

// ctrl fields
`define CTRL_GO      0
`define CTRL_A16     1
`define CTRL_RAWMOV  2
`define CTRL_TWOSRC  3

// exec fields
`define EXEC_LOG     2:0
`define EXEC_TYPE    5:4

// shared origin, decoded as register number and byte subregister
`define F_ORIGIN     15:0
`define IDX_REG      15:5
`define IDX_SUB      4:0

// source fields
`define SRC_HS       17:16
`define SRC_WLOG     22:20
`define SRC_VS       27:24
`define SRC_SIZE     29:28
`define SRC_MODE     31:30

// destination fields
`define DST_STRIDE   17:16
`define DST_SIZE     21:20
`define DST_IND      24

// status fields
`define ST_BUSY      0
`define ST_DONE      1
`define ST_REJECT    2
`define ST_ILLEGAL   3

// region geometry in bytes, element sizes as log2 byte codes
`define GRF_BYTES    12'h020
`define HALF_BYTES   12'h010
`define SPAN_LIMIT   12'h040
`define EXEC_LIMIT   12'h040
`define SIZE_DF      2'h3
`define SIZE_W       2'h1
`define SIZE_D       2'h2

`endif

// >>> design/region_host_pkg.sv
// types shared by the operand region host controller
package region_host_pkg;

	typedef enum logic [1:0] {
		MODE_DIRECT = 2'b00,
		MODE_ONE    = 2'b01,
		MODE_ROW    = 2'b10,
		MODE_ELEM   = 2'b11
	} addr_mode_t;

	typedef struct packed {
		logic [15:0] origin;
		logic [1:0]  hs;
		logic [2:0]  wlog;
		logic [3:0]  vs;
		logic [1:0]  size;
		addr_mode_t  mode;
	} src_region_t;

	typedef struct packed {
		logic [15:0] origin;
		logic [1:0]  stride;
		logic [1:0]  size;
		logic        indirect;
	} dst_region_t;

	typedef struct packed {
		logic        valid;
		logic        sixteen_byte_aligned_access;
		logic        raw_mov;
		logic        two_src;
		logic [2:0]  exec_log;
		logic [1:0]  etype;
		dst_region_t dst;
		src_region_t first_source;
		src_region_t second_source;
	} issue_t;

	typedef struct packed {
		logic ack;
		logic illegal;
	} answer_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_CHECK = 2'b01,
		ST_ISSUE = 2'b10
	} host_state_t;

endpackage : region_host_pkg

// >>> design/src_region_check.sv
// legality checks for one source region
`timescale 1ns/100ps
`include "region_host_params.svh"
module src_region_check
	import region_host_pkg::*;
#(
	parameter bit IS_SECOND = 1'b0
) (
	// region under test
	input  wire src_region_t r,
	input  wire logic [2:0]  exec_log,
	input  wire logic        sixteen_byte_aligned_access,
	// results
	output logic [8:0]       fail,
	output logic             two_reg,
	output logic             scalar,
	output logic             packed_word,
	output logic             half_ok
);
	logic [11:0] sz, hsb, vsb, w, rows, sub, row_span, last_row, last;
	logic [11:0] half, half_off, first_end, last_end;
	logic        hs_zero, vs_zero, direct;

	assign hs_zero   = (r.hs == 2'h0);
	assign vs_zero   = (r.vs == 4'h0);
	assign direct    = (r.mode == MODE_DIRECT);
	assign sz        = 12'h1 << r.size;
	assign hsb       = hs_zero ? 12'h0 : (sz << (r.hs - 2'h1));
	assign vsb       = vs_zero ? 12'h0 : (sz << (r.vs - 4'h1));
	assign w         = 12'h1 << r.wlog;
	assign rows      = (exec_log >= r.wlog) ?
		(12'h1 << (exec_log - r.wlog)) : 12'h1;
	assign sub       = {7'h0, r.origin[`IDX_SUB]};
	assign row_span  = 12'((w - 12'h1) * hsb);
	assign last_row  = 12'(sub + (rows - 12'h1) * vsb);
	assign last      = last_row + row_span + sz - 12'h1;
	assign half      = (12'h1 << exec_log) >> 1;
	assign half_off  = 12'((half >> r.wlog) * vsb + (half & (w - 12'h1)) * hsb);
	assign first_end = {7'h0, sub[4:0]} + row_span + sz - 12'h1;
	assign last_end  = {7'h0, last_row[4:0]} + row_span + sz - 12'h1;

	assign fail[0] = exec_log < r.wlog;
	assign fail[1] = (exec_log == r.wlog) && !hs_zero &&
		(vsb != 12'((w * hsb)));
	assign fail[2] = (r.wlog == 3'h0) && !hs_zero;
	assign fail[3] = (exec_log == 3'h0) && (r.wlog == 3'h0) &&
		!(hs_zero && vs_zero);
	assign fail[4] = hs_zero && vs_zero && (r.wlog != 3'h0);
	assign fail[5] = (first_end >= `GRF_BYTES) ||
		(last_end >= `GRF_BYTES);
	assign fail[6] = direct && (last >= `SPAN_LIMIT);
	assign fail[7] = (sixteen_byte_aligned_access && (sub[3:0] != 4'h0)) ||
		((r.size == `SIZE_DF) && (sub[2:0] != 3'h0));
	assign fail[8] = IS_SECOND && !(direct || r.mode == MODE_ONE);

	assign two_reg     = last >= `GRF_BYTES;
	assign scalar      = hs_zero && vs_zero && (r.wlog == 3'h0);
	assign packed_word = (r.size == `SIZE_W) && (r.hs == 2'h1) &&
		((r.wlog == exec_log) || (vsb == 12'(w * hsb)));
	assign half_ok     = half_off == `GRF_BYTES;

endmodule : src_region_check

// >>> design/dst_region_check.sv
// legality checks for the destination region
`timescale 1ns/100ps
`include "region_host_params.svh"
module dst_region_check
	import region_host_pkg::*;
(
	// region under test
	input  wire dst_region_t d,
	input  wire logic [2:0]  exec_log,
	input  wire logic [1:0]  etype,
	input  wire logic        sixteen_byte_aligned_access,
	input  wire logic        raw_mov,
	// results
	output logic [6:0]       fail,
	output logic             two_reg,
	output logic             split_quarter,
	output logic             split_half,
	output logic             in_low,
	output logic             in_high
);
	logic [11:0] sz, sb, esz, sub, last, half_span, lane_off;
	logic        byte_dst;

	assign sz        = 12'h1 << d.size;
	assign sb        = (d.stride == 2'h0) ? 12'h0 :
		(sz << (d.stride - 2'h1));
	assign esz       = 12'h1 << etype;
	assign sub       = {7'h0, d.origin[`IDX_SUB]};
	assign last      = 12'(sub + ((12'h1 << exec_log) - 12'h1) * sb) + sz - 12'h1;
	assign half_span = 12'(((12'h1 << exec_log) >> 1) * sb);
	assign lane_off  = sub & (esz - 12'h1);
	assign byte_dst  = d.size == 2'h0;

	assign fail[0] = d.stride == 2'h0;
	assign fail[1] = !((lane_off == 12'h0) ||
		(byte_dst && lane_off == 12'h1));
	assign fail[2] = (exec_log != 3'h0) && (sb < esz);
	assign fail[3] = (etype > d.size) && (sb != esz);
	assign fail[4] = byte_dst && (d.stride == 2'h1) && !raw_mov;
	assign fail[5] = last >= `SPAN_LIMIT;
	assign fail[6] = (sixteen_byte_aligned_access && (sub[3:0] != 4'h0)) ||
		((d.size == `SIZE_DF) && (sub[2:0] != 3'h0));

	assign two_reg       = last >= `GRF_BYTES;
	assign split_quarter = (exec_log != 3'h0) && (half_span == `HALF_BYTES);
	assign split_half    = (exec_log != 3'h0) && (half_span == `GRF_BYTES);
	assign in_low        = last < `HALF_BYTES;
	assign in_high       = sub >= `HALF_BYTES;

endmodule : dst_region_check

// >>> design/region_host.sv
// host controller: software sets up an operand region over apb, it is
// screened and then issued to the region checker
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "region_host_params.svh"
module region_host
	import region_host_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// link to the region checker
	output issue_t           issue,
	input  wire answer_t     answer
);
	////////////////////////////////////////////////////////////////////////
	// configuration registers
	logic        a16_reg, a16_next;
	logic        rawmov_reg, rawmov_next;
	logic        twosrc_reg, twosrc_next;
	logic [2:0]  exec_log_reg, exec_log_next;
	logic [1:0]  etype_reg, etype_next;
	dst_region_t dst_reg, dst_next;
	src_region_t first_source_reg, first_source_next;
	src_region_t second_source_reg, second_source_next;

	// status registers
	host_state_t state_reg, state_next;
	logic        done_reg, done_next;
	logic        reject_reg, reject_next;
	logic        illegal_reg, illegal_next;
	logic [29:0] viol_reg, viol_next;
	issue_t      issue_reg, issue_next;

	// bus output registers
	logic [31:0] prdata_reg, prdata_next;
	logic        pready_reg, pready_next;
	logic        pslverr_reg, pslverr_next;

	////////////////////////////////////////////////////////////////////////
	// apb decode: one wait state, answer registered
	logic        access, wr, hit_ctrl, hit_exec, hit_dst, hit_first_source, hit_second_source;
	logic        hit_status, hit_viol, mapped, go_wr;
	logic [31:0] status_word, rd_word;

	assign access     = psel && penable && !pready_reg;
	assign wr         = access && pwrite;
	assign hit_ctrl   = paddr == `OFF_CTRL;
	assign hit_exec   = paddr == `OFF_EXEC;
	assign hit_dst    = paddr == `OFF_DST;
	assign hit_first_source   = paddr == `OFF_FIRST_SOURCE;
	assign hit_second_source   = paddr == `OFF_SECOND_SOURCE;
	assign hit_status = paddr == `OFF_STATUS;
	assign hit_viol   = paddr == `OFF_VIOL;
	assign mapped     = hit_ctrl | hit_exec | hit_dst | hit_first_source |
		hit_second_source | hit_status | hit_viol;
	assign go_wr      = wr && hit_ctrl && pwdata[`CTRL_GO];

	assign status_word = {28'h0, illegal_reg, reject_reg, done_reg,
		state_reg != ST_IDLE};

	assign rd_word =
		hit_ctrl   ? {28'h0, twosrc_reg, rawmov_reg, a16_reg, 1'b0} :
		hit_exec   ? {26'h0, etype_reg, 1'b0, exec_log_reg} :
		hit_dst    ? {7'h0, dst_reg.indirect, 2'h0, dst_reg.size,
			2'h0, dst_reg.stride, dst_reg.origin} :
		hit_first_source   ? {first_source_reg.mode, first_source_reg.size, first_source_reg.vs, 1'b0,
			first_source_reg.wlog, 2'h0, first_source_reg.hs, first_source_reg.origin} :
		hit_second_source   ? {second_source_reg.mode, second_source_reg.size, second_source_reg.vs, 1'b0,
			second_source_reg.wlog, 2'h0, second_source_reg.hs, second_source_reg.origin} :
		hit_status ? status_word :
		hit_viol   ? {2'h0, viol_reg} : 32'h0;

	assign pready_next  = access;
	assign pslverr_next = access && !mapped;
	assign prdata_next  = (access && !pwrite) ? rd_word : 32'h0;

	////////////////////////////////////////////////////////////////////////
	// field writes, held while an order is in flight
	logic cfg_wr;

	assign cfg_wr = wr && (state_reg == ST_IDLE);

	assign a16_next    = (cfg_wr && hit_ctrl) ? pwdata[`CTRL_A16] : a16_reg;
	assign rawmov_next = (cfg_wr && hit_ctrl) ?
		pwdata[`CTRL_RAWMOV] : rawmov_reg;
	assign twosrc_next = (cfg_wr && hit_ctrl) ?
		pwdata[`CTRL_TWOSRC] : twosrc_reg;
	assign exec_log_next = (cfg_wr && hit_exec) ?
		pwdata[`EXEC_LOG] : exec_log_reg;
	assign etype_next  = (cfg_wr && hit_exec) ? pwdata[`EXEC_TYPE] : etype_reg;
	assign dst_next    = (cfg_wr && hit_dst) ?
		dst_region_t'{origin: pwdata[`F_ORIGIN], stride: pwdata[`DST_STRIDE],
		size: pwdata[`DST_SIZE], indirect: pwdata[`DST_IND]} : dst_reg;
	assign first_source_next   = (cfg_wr && hit_first_source) ? src_field(pwdata) : first_source_reg;
	assign second_source_next   = (cfg_wr && hit_second_source) ? src_field(pwdata) : second_source_reg;

	function automatic src_region_t src_field(input logic [31:0] v);
		src_region_t s;
		s.origin = v[`F_ORIGIN];
		s.hs     = v[`SRC_HS];
		s.wlog   = v[`SRC_WLOG];
		s.vs     = v[`SRC_VS];
		s.size   = v[`SRC_SIZE];
		s.mode   = addr_mode_t'(v[`SRC_MODE]);
		return s;
	endfunction : src_field

	////////////////////////////////////////////////////////////////////////
	// region screening
	logic [8:0]  s0_fail, s1_fail;
	logic [6:0]  d_fail;
	logic        s0_two, s0_scalar, s0_pword, s0_half;
	logic        s1_two, s1_scalar, s1_pword, s1_half;
	logic        d_two, d_quarter, d_split, d_low, d_high;

	src_region_check #(.IS_SECOND(1'b0)) u_first_source (
		.r           (first_source_reg),
		.exec_log    (exec_log_reg),
		.sixteen_byte_aligned_access     (a16_reg),
		.fail        (s0_fail),
		.two_reg     (s0_two),
		.scalar      (s0_scalar),
		.packed_word (s0_pword),
		.half_ok     (s0_half)
	);

	src_region_check #(.IS_SECOND(1'b1)) u_second_source (
		.r           (second_source_reg),
		.exec_log    (exec_log_reg),
		.sixteen_byte_aligned_access     (a16_reg),
		.fail        (s1_fail),
		.two_reg     (s1_two),
		.scalar      (s1_scalar),
		.packed_word (s1_pword),
		.half_ok     (s1_half)
	);

	dst_region_check u_dst (
		.d             (dst_reg),
		.exec_log      (exec_log_reg),
		.etype         (etype_reg),
		.sixteen_byte_aligned_access       (a16_reg),
		.raw_mov       (rawmov_reg),
		.fail          (d_fail),
		.two_reg       (d_two),
		.split_quarter (d_quarter),
		.split_half    (d_split),
		.in_low        (d_low),
		.in_high       (d_high)
	);

	logic [1:0]  max_size;
	logic [11:0] exec_bytes;
	logic        s1_two_used, s1_ok_two, s0_ok_two, double_word_type_dst;
	logic [4:0]  combo_fail;
	logic [8:0]  s1_fail_used;
	logic        any_fail;

	assign max_size = (first_source_reg.size > dst_reg.size) ?
		first_source_reg.size : dst_reg.size;
	assign exec_bytes = (12'h1 << exec_log_reg) <<
		((twosrc_reg && second_source_reg.size > max_size) ? second_source_reg.size : max_size);
	assign s1_two_used  = twosrc_reg && s1_two;
	assign s1_fail_used = twosrc_reg ? s1_fail : 9'h0;
	assign double_word_type_dst    = (dst_reg.size == `SIZE_D) && (dst_reg.stride == 2'h1);
	assign s0_ok_two    = s0_two || s0_scalar || (s0_pword && double_word_type_dst);
	assign s1_ok_two    = !twosrc_reg || s1_two || s1_scalar ||
		(s1_pword && double_word_type_dst);

	assign combo_fail[0] = exec_bytes > `EXEC_LIMIT;
	assign combo_fail[1] = (s0_two || s1_two_used) && !d_two &&
		!(d_low || d_high || d_quarter);
	assign combo_fail[2] = d_two && (s0_two || s1_two_used) &&
		(!d_split || (s0_two && !s0_half) ||
		(s1_two_used && !s1_half));
	assign combo_fail[3] = d_two && !(s0_ok_two && s1_ok_two);
	assign combo_fail[4] = ((first_source_reg.mode == MODE_ROW) ||
		(first_source_reg.mode == MODE_ELEM)) && d_two;

	assign any_fail = |{combo_fail, d_fail, s1_fail_used, s0_fail};

	////////////////////////////////////////////////////////////////////////
	// order sequencing
	issue_t issue_cfg;

	// origins go out as index values, register over byte
	assign issue_cfg = '{valid: 1'b1, sixteen_byte_aligned_access: a16_reg, raw_mov: rawmov_reg,
		two_src: twosrc_reg, exec_log: exec_log_reg, etype: etype_reg,
		dst: dst_reg, first_source: first_source_reg, second_source: second_source_reg};

	always_comb begin
		state_next   = state_reg;
		done_next    = done_reg;
		reject_next  = reject_reg;
		illegal_next = illegal_reg;
		viol_next    = viol_reg;
		issue_next   = issue_reg;
		case (state_reg)
			ST_IDLE: begin
				if (go_wr) begin
					done_next    = 1'b0;
					reject_next  = 1'b0;
					illegal_next = 1'b0;
					state_next   = ST_CHECK;
				end
			end
			ST_CHECK: begin
				// dst indirect always goes out as one index
				viol_next = {combo_fail, d_fail, s1_fail_used, s0_fail};
				if (any_fail) begin
					reject_next = 1'b1;
					done_next   = 1'b1;
					state_next  = ST_IDLE;
				end else begin
					issue_next = issue_cfg;
					state_next = ST_ISSUE;
				end
			end
			ST_ISSUE: begin
				// checker splits halves itself
				if (answer.ack) begin
					issue_next.valid = 1'b0;
					illegal_next     = answer.illegal;
					done_next        = 1'b1;
					state_next       = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a16_reg      <= 1'b0;
			rawmov_reg   <= 1'b0;
			twosrc_reg   <= 1'b0;
			exec_log_reg <= 3'h0;
			etype_reg    <= 2'h0;
			dst_reg      <= '0;
			first_source_reg     <= '0;
			second_source_reg     <= '0;
		end else begin
			a16_reg      <= a16_next;
			rawmov_reg   <= rawmov_next;
			twosrc_reg   <= twosrc_next;
			exec_log_reg <= exec_log_next;
			etype_reg    <= etype_next;
			dst_reg      <= dst_next;
			first_source_reg     <= first_source_next;
			second_source_reg     <= second_source_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg   <= ST_IDLE;
			done_reg    <= 1'b0;
			reject_reg  <= 1'b0;
			illegal_reg <= 1'b0;
			viol_reg    <= 30'h0;
			issue_reg   <= '0;
		end else begin
			state_reg   <= state_next;
			done_reg    <= done_next;
			reject_reg  <= reject_next;
			illegal_reg <= illegal_next;
			viol_reg    <= viol_next;
			issue_reg   <= issue_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg  <= 32'h0;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;
	assign issue   = issue_reg;

endmodule : region_host

// >>> sim/region_host_properties.sv
// port checker for the region host controller
`timescale 1ns/100ps
module region_host_properties
	import region_host_pkg::*;
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// checker link
	input wire issue_t      issue,
	input wire answer_t     answer
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////
	wire logic take = psel && penable && !pready;
	wire logic go_wr = take && pwrite && paddr == 8'h00 && pwdata[0];
	property p_one_wait; take |=> pready; endproperty
	a_one_wait: assert property (p_one_wait)
		else $error("pready not one cycle after access");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("pready held");
	property p_access; pready |-> psel && penable; endproperty
	a_access: assert property (p_access) else $error("pready outside access");
	property p_err_ready; pslverr |-> pready; endproperty
	a_err_ready: assert property (p_err_ready) else $error("stray pslverr");
	property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero");
	property p_unmapped;
		take && paddr > 8'h18 |=> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("no error response");
	property p_hold;
		issue.valid && !answer.ack |=> issue.valid && $stable(issue);
	endproperty
	a_hold: assert property (p_hold) else $error("issue changed early");
	property p_release; issue.valid && answer.ack |=> !issue.valid; endproperty
	a_release: assert property (p_release) else $error("valid after ack");
	property p_from_go;
		$rose(issue.valid) |-> $past(go_wr, 2) || $past(go_wr, 3);
	endproperty
	a_from_go: assert property (p_from_go) else $error("issue without go");
endmodule : region_host_properties
bind region_host region_host_properties u_props (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .issue(issue), .answer(answer));

// >>> sim/region_device_model.sv
// behavioural model of the region checker behind the host
`timescale 1ns/100ps
module region_device_model
	import region_host_pkg::*;
(
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// link
	input wire issue_t     issue,
	output answer_t        answer,
	// scenario control
	input wire logic [4:0] delay,
	input wire logic       force_illegal,
	output int             issue_count
);
	int wait_cnt;
	// origin as register number and byte subregister
	wire logic [10:0] dst_reg = issue.dst.origin[15:5];
	wire logic [4:0]  dst_sub = issue.dst.origin[4:0];
	// second half: next index register, scalar keeps its own
	wire logic [10:0] hi_reg = dst_reg + 11'h1;
	wire logic scalar0 = issue.first_source.wlog == 3'h0;
	// byte destination accepted at byte 0 or 1 of the channel
	wire logic byte_odd = issue.dst.size == 2'h0 && dst_sub[0];
	// double lanes taken as float pairs in both modes
	wire logic dbl = issue.dst.size == 2'h3;
	wire logic bad = force_illegal || issue.dst.stride == 2'h0;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			answer <= '0;
			wait_cnt <= 0;
			issue_count <= 0;
		end else begin
			answer <= '0;
			if (issue.valid && !answer.ack) begin
				if (wait_cnt >= delay) begin
					answer <= {1'b1, bad};
					wait_cnt <= 0;
					issue_count <= issue_count + 1;
				end else
					wait_cnt <= wait_cnt + 1;
			end
		end
	end
endmodule : region_device_model

// >>> sim/tb_top.sv
// self-checking bench for the region host controller
`timescale 1ns/100ps
`include "region_host_params.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_top
	import region_host_pkg::*;
;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd;
	logic        err, force_illegal = 0;
	logic [4:0]  delay = 5'h2;
	wire logic [31:0] prdata;
	wire logic   pready, pslverr;
	wire issue_t issue;
	wire answer_t answer;
	int          issue_count, failures = 0, check_count = 0, rr;
	localparam logic [31:0] c0 = 32'h9, e0 = 32'h23, d0 = 32'h0021_0000;
	localparam logic [31:0] s0 = 32'h2431_0040, s1 = 32'h2431_0060;
	// rows: ctrl, exec, dst, first_source, second_source, expected violation bits
	logic [31:0] tbl [22][6] = '{
		'{c0, e0, d0, s0, s1, 0},
		'{c0, 32'h13, 32'h0002_0001, 32'h1431_0040, 32'h1431_0060, 0},
		'{c0, 32'h24, d0, 32'h2000_0040, 32'h2431_0080, 0},
		'{c0, e0, 32'h0020_0000, s0, s1, 32'h0004_0000},
		'{c0, e0, d0, 32'h2401_0040, s1, 32'h4},
		'{c0, 32'h22, d0, s0, s1, 32'h1},
		'{c0, e0, d0, 32'h2331_0040, s1, 32'h2},
		'{c0, e0, d0, 32'h2030_0040, s1, 32'h10},
		'{c0, 32'h20, d0, 32'h2100_0040, s1, 32'h8},
		'{c0, e0, d0, 32'h2431_0050, s1, 32'h20},
		'{c0, 32'h24, d0, 32'h2531_0040, s1, 32'h40},
		'{c0, 32'h25, d0, s0, s1, 32'h0200_0000},
		'{c0, e0, 32'h0001_0000, s0, s1, 32'h0040_0000},
		'{c0, e0, d0, s0, 32'ha431_0060, 32'h0002_0000},
		'{32'hb, e0, d0, 32'h2431_0044, s1, 32'h80},
		'{c0, e0, 32'h0011_0000, s0, s1, 32'h0020_0000},
		'{c0, 32'h24, d0, 32'ha431_0040, s1, 32'h2000_0000},
		'{32'h1, 32'h13, 32'h0011_0004, 32'h1321_0058, s1, 32'h0400_0000},
		'{32'h1, 32'h24, d0, 32'h1431_0050, s1, 32'h0800_0000},
		'{c0, 32'h24, d0, 32'h2031_0040, s1, 32'h1000_0000},
		'{c0, e0, 32'h0021_0002, s0, s1, 32'h0008_0000},
		'{c0, e0, 32'h0031_0004, s0, s1, 32'h0100_0000}
	};
	always #5 pclk = ~pclk;
	region_host dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .issue(issue),
		.answer(answer));
	region_device_model partner (.pclk(pclk), .presetn(presetn),
		.issue(issue), .answer(answer), .delay(delay),
		.force_illegal(force_illegal), .issue_count(issue_count));
	////////////////////////////////////////
	function logic [3:0] exp_status(input logic rej, input logic ill);
		return {ill, rej, 1'b1, 1'b0};
	endfunction : exp_status
	task print_verdict;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// hold the request until pready is sampled high at a rising edge
		do begin @(posedge pclk); end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task run(input logic [31:0] c, e, d, a, b, m, input logic poke);
		int n, cnt0;
		cnt0 = issue_count;
		apb(1'b1, `OFF_DST, d);
		apb(1'b1, `OFF_FIRST_SOURCE, a);
		apb(1'b1, `OFF_SECOND_SOURCE, b);
		apb(1'b1, `OFF_EXEC, e);
		apb(1'b1, `OFF_CTRL, c);
		if (m == 0) begin
			n = 0;
			while (issue.valid !== 1'b1 && n < 10) begin @(posedge pclk); n++; end
			`CHK(issue.valid, 1'b1)
			`CHK(issue.dst.origin, d[15:0])
			`CHK(issue.first_source.origin, a[15:0])
			if (poke) begin
				apb(1'b1, `OFF_DST, 32'h0);
				apb(1'b1, `OFF_CTRL, c);
			end
		end
		n = 0;
		do begin apb(1'b0, `OFF_STATUS, 0); n++; end
			while (rd[1] !== 1'b1 && n < 40);
		if (m == 0) begin
			`CHK(rd[3:0], exp_status(1'b0, force_illegal))
			`CHK(issue_count, cnt0 + 1)
		end else begin
			`CHK(rd[3:0], exp_status(1'b1, 1'b0))
			`CHK(issue_count, cnt0)
			apb(1'b0, `OFF_VIOL, 0);
			`CHK(rd & m, m)
		end
		if (poke) begin apb(1'b0, `OFF_DST, 0); `CHK(rd, d) end
		apb(1'b0, `OFF_CTRL, 0);
		`CHK(rd[0], 1'b0)
	endtask : run
	initial begin
		void'($urandom(28));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `OFF_STATUS, 0);
		`CHK(rd, 32'h0)
		apb(1'b0, `OFF_VIOL, 0);
		`CHK(rd, 32'h0)
		apb(1'b0, 8'h1c, 0);
		`CHK({err, rd}, 33'h1_0000_0000)
		foreach (tbl[i])
			run(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3], tbl[i][4],
				tbl[i][5], 1'b0);
		apb(1'b1, `OFF_STATUS, 32'hff);
		apb(1'b0, `OFF_STATUS, 0);
		`CHK(rd[3:0], exp_status(1'b1, 1'b0))
		for (int i = 0; i < 8; i++) begin
			rr = $urandom % 120;
			delay <= (i == 0) ? 5'd20 : 5'($urandom % 8);
			force_illegal <= 1'($urandom % 2);
			run(c0, e0, d0 | {rr[10:0], 5'h0}, 32'h2431_0000 | {rr[10:0], 5'h0},
				s1, 0, i == 0);
		end
		print_verdict();
	end
	initial begin
		repeat (30000) @(posedge pclk);
		failures++;
		print_verdict();
	end
endmodule : tb_top
